/* hdl/itdm_pkg.sv */
// Constants, register map and state encoding shared by the data mover design.
package itdm_pkg;

  // ****************************************************************
  // Register map of the bus slave, byte addresses.
  // ****************************************************************
  localparam logic [7:0]  ITDM_ACT_EN_OFS   = 8'h00;     // Activation enable bits, one per source.
  localparam logic [7:0]  ITDM_ACT_CTL_OFS  = 8'h04;     // Activation control byte, non-maskable seen flag.
  localparam logic [7:0]  ITDM_STATUS_OFS   = 8'h08;     // Engine status, read only.
  localparam logic [7:0]  ITDM_PEND_OFS     = 8'h0C;     // Pending activations, read only.
  localparam int          ITDM_NONMASKABLE_SEEN_FLAG_BIT     = 1;         // Position of the non-maskable seen flag.
  localparam logic [1:0]  ITDM_RESP_OKAY    = 2'h0;      // Normal bus answer.
  localparam logic [1:0]  ITDM_RESP_SLVERR  = 2'h2;      // Answer to an unmapped address.

  // ****************************************************************
  // Control data layout in system memory.
  // ****************************************************************
  localparam int          ITDM_NSETS        = 24;        // Number of control data sets.
  localparam logic [15:0] ITDM_CD_BASE      = 16'h2C40;  // First byte of set 0.
  localparam logic [15:0] ITDM_CD_LAST      = 16'h2CFF;  // Last byte of the control data area.
  localparam logic [4:0]  ITDM_LAST_SET     = 5'h17;     // Index of the last set.
  localparam int          ITDM_CD_CTL       = 0;         // Byte index of the control byte.
  localparam int          ITDM_CD_BLK       = 1;         // Byte index of the block size byte.
  localparam int          ITDM_CD_CNT       = 2;         // Byte index of the transfer count byte.
  localparam int          ITDM_CD_RLD       = 3;         // Byte index of the count reload byte.
  localparam int          ITDM_CD_SAR       = 4;         // Byte index of the source address, low byte first.
  localparam int          ITDM_CD_DAR       = 6;         // Byte index of the destination address, low byte first.
  localparam int          ITDM_MODE_BIT     = 0;         // 0 normal mode, 1 repeat mode.
  localparam int          ITDM_RSEL_BIT     = 1;         // 0 destination repeats, 1 source repeats.
  localparam int          ITDM_SINC_BIT     = 2;         // Source address increments when 1.
  localparam int          ITDM_DINC_BIT     = 3;         // Destination address increments when 1.
  localparam int          ITDM_CHAIN_BIT    = 4;         // Chain to the following set when 1.
  localparam int          ITDM_RINT_BIT     = 5;         // Repeat mode interrupt enable.

  // ****************************************************************
  // Engine states.
  // ****************************************************************
  typedef enum logic [2:0] {
    ITDM_IDLE  = 3'b000,
    ITDM_RD_CD = 3'b001,
    ITDM_MV_RD = 3'b010,
    ITDM_MV_WR = 3'b011,
    ITDM_WB    = 3'b100
  } itdm_state_e;

endpackage

/* hdl/itdm_data_mover.sv */
// Interrupt triggered data mover with AXI4-Lite registers and a byte wide system bus master.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
// Overview of operation
// - Shares system bus, wins over processor
// - 64 Kbyte addresses, one byte per move
// - Load set on activation, write back after
// - Working copy hidden; sets live in memory
// - Enabled source event starts a transfer
// - Normal mode ends on count one to zero
// - Repeat mode restores address, reloads count
// - Non repeat side follows its increment bit
// - Normal final transfer of the source's own set raises its interrupt
// - Repeat final interrupts only when enabled
// - Cleared enable bit stops further activation
// - Bit zero selects normal or repeat
// - Bit one selects which side repeats
// - Bits two, three fix or increment
// - Block size zero means 256 bytes
// - Transfer count zero means 256 transfers
// - Count drops by one per activation
// - Source address is full 16 bits
// - Chain bit continues with the next set, ignored on the last set
// - Interrupting final transfer clears the source enable
// - Non-maskable flag blocks new activations only
// - Activation ignores processor masking entirely
module itdm_data_mover
  import itdm_pkg::*;
#(
  parameter int NSRC = ITDM_NSETS  // Number of activation sources and sets.
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NSRC-1:0]   act_event,
  input  wire logic              nmi_event,
  input  wire logic              cpu_bus_req,
  output logic                   cpu_bus_grant,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [15:0]            mem_addr,
  output logic [7:0]             mem_wdata,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic              mem_ack,
  output logic [NSRC-1:0]        irq_req
);

  // ****************************************************************
  // State of the whole module.
  // ****************************************************************
  typedef struct packed {
    itdm_state_e      st;        // Engine state.
    logic [NSRC-1:0]  en;        // Activation enable bits.
    logic [NSRC-1:0]  pend;      // Latched activations awaiting service.
    logic             nonmaskable_seen_flag;      // Non-maskable seen flag.
    logic             nonmaskable_seen_flag_seen; // Flag was read as one since it last rose.
    logic [4:0]       set_idx;   // Set being worked on.
    logic [4:0]       src_idx;   // Source that started this activation.
    logic             first;     // Working on the first set of a chain.
    logic             fin;       // First set reached a final transfer that interrupts.
    logic [2:0]       k;         // Byte index within the control data.
    logic [8:0]       left;      // Bytes left in the current block.
    logic [7:0]       data;      // Byte held between read and write.
    logic [7:0][7:0]  cd;        // Working copy of the control data.
    logic             mreq;
    logic             mwe;
    logic [15:0]      maddr;
    logic [7:0]       mwdata;
    logic [NSRC-1:0]  irq;
    logic             grant;
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } itdm_state_s;

  itdm_state_s r_reg;  // Registered state.
  itdm_state_s r_next; // Next state.

  // Lowest pending index wins; index zero has the highest priority.
  function automatic logic [4:0] itdm_prio(input logic [NSRC-1:0] p);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // Address of byte k of a given set in the control data area.
  function automatic logic [15:0] itdm_cd_addr(input logic [4:0] s, input logic [2:0] k);
    return ITDM_CD_BASE + {8'h00, s, k};
  endfunction

  // ****************************************************************
  // Next state logic.
  // ****************************************************************
  always_comb begin
    logic [7:0]  ctl;
    logic [15:0] sar;
    logic [15:0] dar;
    logic [8:0]  blkn;
    logic [8:0]  rldn;
    logic [17:0] span;
    logic        rpt;
    logic        s_inc;
    logic        d_inc;
    logic        last;
    logic [7:0]  cnt_n;
    logic [31:0] rd;
    logic        hit;
    ctl    = r_reg.cd[ITDM_CD_CTL];
    sar    = {r_reg.cd[ITDM_CD_SAR+1], r_reg.cd[ITDM_CD_SAR]};
    dar    = {r_reg.cd[ITDM_CD_DAR+1], r_reg.cd[ITDM_CD_DAR]};
    blkn   = (r_reg.cd[ITDM_CD_BLK] == 8'h00) ? 9'h100 : {1'b0, r_reg.cd[ITDM_CD_BLK]};
    rldn   = (r_reg.cd[ITDM_CD_RLD] == 8'h00) ? 9'h100 : {1'b0, r_reg.cd[ITDM_CD_RLD]};
    span   = blkn * rldn;
    rpt    = ctl[ITDM_MODE_BIT];
    // The repeat side always walks its area; the other side obeys its own bit.
    s_inc  = (rpt && ctl[ITDM_RSEL_BIT]) ? 1'b1 : ctl[ITDM_SINC_BIT];
    d_inc  = (rpt && !ctl[ITDM_RSEL_BIT]) ? 1'b1 : ctl[ITDM_DINC_BIT];
    last   = (r_reg.cd[ITDM_CD_CNT] == 8'h01);
    cnt_n  = r_reg.cd[ITDM_CD_CNT] - 8'h01;
    rd     = 32'h0000_0000;
    hit    = 1'b1;
    r_next = r_reg;
    r_next.irq = '0;

    // ****************************************************************
    // Transfer engine.
    // ****************************************************************
    unique case (r_reg.st)
      ITDM_IDLE: begin
        // A single engine serves one source at a time, by priority.
        if (|r_reg.pend) begin
          r_next.set_idx = itdm_prio(r_reg.pend);
          r_next.src_idx = itdm_prio(r_reg.pend);
          r_next.pend[itdm_prio(r_reg.pend)] = 1'b0;
          r_next.first = 1'b1;
          r_next.fin = 1'b0;
          r_next.k = 3'h0;
          r_next.st = ITDM_RD_CD;
        end
      end
      ITDM_RD_CD: begin
        // Load the selected set into the hidden working copy, byte by byte.
        if (!r_reg.mreq) begin
          r_next.mreq = 1'b1;
          r_next.mwe = 1'b0;
          r_next.maddr = itdm_cd_addr(r_reg.set_idx, r_reg.k);
        end else if (mem_ack) begin
          r_next.mreq = 1'b0;
          r_next.cd[r_reg.k] = mem_rdata;
          r_next.k = r_reg.k + 3'h1;
          if (r_reg.k == 3'h7) begin
            r_next.st = ITDM_MV_RD;
            r_next.left = (r_next.cd[ITDM_CD_BLK] == 8'h00) ? 9'h100 : {1'b0, r_next.cd[ITDM_CD_BLK]};
          end
        end
      end
      ITDM_MV_RD: begin
        // Each move reads one byte from the source address.
        if (!r_reg.mreq) begin
          r_next.mreq = 1'b1;
          r_next.mwe = 1'b0;
          r_next.maddr = sar;
        end else if (mem_ack) begin
          r_next.mreq = 1'b0;
          r_next.data = mem_rdata;
          r_next.st = ITDM_MV_WR;
        end
      end
      ITDM_MV_WR: begin
        // Then writes it to the destination and steps the addresses.
        if (!r_reg.mreq) begin
          r_next.mreq = 1'b1;
          r_next.mwe = 1'b1;
          r_next.maddr = dar;
          r_next.mwdata = r_reg.data;
        end else if (mem_ack) begin
          r_next.mreq = 1'b0;
          sar = s_inc ? sar + 16'h0001 : sar;
          dar = d_inc ? dar + 16'h0001 : dar;
          r_next.left = r_reg.left - 9'h001;
          if (r_reg.left == 9'h001) begin
            // Block done: count the activation and look for the final one.
            r_next.cd[ITDM_CD_CNT] = cnt_n;
            if (last && rpt) begin
              // Wind the repeat side back and reload the count.
              if (ctl[ITDM_RSEL_BIT]) begin
                sar = sar - span[15:0];
              end else begin
                dar = dar - span[15:0];
              end
              r_next.cd[ITDM_CD_CNT] = r_reg.cd[ITDM_CD_RLD];
            end
            if (r_reg.first) begin
              r_next.fin = last && (!rpt || ctl[ITDM_RINT_BIT]);
            end
            r_next.k = 3'h0;
            r_next.st = ITDM_WB;
          end else begin
            r_next.st = ITDM_MV_RD;
          end
          r_next.cd[ITDM_CD_SAR]   = sar[7:0];
          r_next.cd[ITDM_CD_SAR+1] = sar[15:8];
          r_next.cd[ITDM_CD_DAR]   = dar[7:0];
          r_next.cd[ITDM_CD_DAR+1] = dar[15:8];
        end
      end
      ITDM_WB: begin
        // Write the updated working copy back into the same set.
        if (!r_reg.mreq) begin
          r_next.mreq = 1'b1;
          r_next.mwe = 1'b1;
          r_next.maddr = itdm_cd_addr(r_reg.set_idx, r_reg.k);
          r_next.mwdata = r_reg.cd[r_reg.k];
        end else if (mem_ack) begin
          r_next.mreq = 1'b0;
          r_next.k = r_reg.k + 3'h1;
          if (r_reg.k == 3'h7) begin
            // The interrupt goes out only after the final write back.
            if (r_reg.fin) begin
              r_next.irq[r_reg.src_idx] = 1'b1;
              r_next.en[r_reg.src_idx] = 1'b0;
              r_next.fin = 1'b0;
            end
            // A chain bit on the last set is ignored to stay inside the area.
            if (ctl[ITDM_CHAIN_BIT] && (r_reg.set_idx != ITDM_LAST_SET)) begin
              r_next.set_idx = r_reg.set_idx + 5'h01;
              r_next.first = 1'b0;
              r_next.st = ITDM_RD_CD;
            end else begin
              r_next.st = ITDM_IDLE;
            end
          end
        end
      end
    endcase

    // ****************************************************************
    // Register bus, write side.
    // ****************************************************************
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_got = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    // Software writes land after the engine, so a write wins a clash.
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = ITDM_RESP_OKAY;
      unique case ({r_reg.aw_addr[7:2], 2'b00})
        ITDM_ACT_EN_OFS: begin
          for (int b = 0; b < NSRC; b++) begin
            if (r_reg.wstrb[b/8]) begin
              r_next.en[b] = r_reg.wdata[b];
            end
          end
        end
        ITDM_ACT_CTL_OFS: begin
          // Flag clears only by writing zero after it was read as one.
          if (r_reg.wstrb[0] && !r_reg.wdata[ITDM_NONMASKABLE_SEEN_FLAG_BIT] && r_reg.nonmaskable_seen_flag_seen) begin
            r_next.nonmaskable_seen_flag = 1'b0;
            r_next.nonmaskable_seen_flag_seen = 1'b0;
          end
        end
        ITDM_STATUS_OFS, ITDM_PEND_OFS: begin
          r_next.bresp = ITDM_RESP_OKAY;
        end
        default: begin
          r_next.bresp = ITDM_RESP_SLVERR;
        end
      endcase
    end

    // ****************************************************************
    // Register bus, read side.
    // ****************************************************************
    unique case ({s_axi_araddr[7:2], 2'b00})
      ITDM_ACT_EN_OFS:  rd = 32'(r_reg.en);
      ITDM_ACT_CTL_OFS: rd = {30'h0000_0000, r_reg.nonmaskable_seen_flag, 1'b0};
      ITDM_STATUS_OFS:  rd = {16'h0000, 3'h0, r_reg.set_idx, 5'h00, r_reg.st};
      ITDM_PEND_OFS:    rd = 32'(r_reg.pend);
      default:          hit = 1'b0;
    endcase
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rdata = rd;
      r_next.rresp = hit ? ITDM_RESP_OKAY : ITDM_RESP_SLVERR;
      if (({s_axi_araddr[7:2], 2'b00} == ITDM_ACT_CTL_OFS) && r_reg.nonmaskable_seen_flag) begin
        r_next.nonmaskable_seen_flag_seen = 1'b1;
      end
    end

    // ****************************************************************
    // Event capture; a rising event wins over any clear this cycle.
    // ****************************************************************
    if (nmi_event) begin
      r_next.nonmaskable_seen_flag = 1'b1;
      r_next.nonmaskable_seen_flag_seen = 1'b0;
    end
    for (int i = 0; i < NSRC; i++) begin
      // Only the enable and the flag gate activation, never CPU masking.
      if (act_event[i] && r_reg.en[i] && !r_reg.nonmaskable_seen_flag) begin
        r_next.pend[i] = 1'b1;
      end
    end

    // Ready flags follow the held halves so every bus output is a flop.
    r_next.awready = !r_next.aw_got && !r_next.bvalid;
    r_next.wready  = !r_next.w_got && !r_next.bvalid;
    r_next.arready = !r_next.rvalid;
    // The processor gets the bus only while the engine wants none of it.
    r_next.grant = cpu_bus_req && (r_next.st == ITDM_IDLE) && !(|r_next.pend);
  end

  // ****************************************************************
  // State register with synchronous reset.
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.st <= ITDM_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register.
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready  = r_reg.wready;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;
  assign cpu_bus_grant = r_reg.grant;
  assign mem_req       = r_reg.mreq;
  assign mem_we        = r_reg.mwe;
  assign mem_addr      = r_reg.maddr;
  assign mem_wdata     = r_reg.mwdata;
  assign irq_req       = r_reg.irq;

endmodule

/* dv/itdm_data_mover_properties.sv */
// Concurrent checks on the data mover's top level ports.
`timescale 1ns/1ns
module itdm_data_mover_checker
  import itdm_pkg::*;
#(
  parameter int NSRC = ITDM_NSETS  // Number of activation sources.
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            cpu_bus_req,
  input wire logic            cpu_bus_grant,
  input wire logic            mem_req,
  input wire logic            mem_we,
  input wire logic [15:0]     mem_addr,
  input wire logic [7:0]      mem_wdata,
  input wire logic            mem_ack,
  input wire logic [NSRC-1:0] irq_req
);
  // ****************************************************************
  // Bus ownership, memory handshake, interrupt pulses, register reads.
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_grant_excl; cpu_bus_grant |-> !mem_req; endproperty
  a_grant_excl: assert property (p_grant_excl) else $error("grant while engine owns bus");
  property p_grant_lag; cpu_bus_grant |-> $past(cpu_bus_req); endproperty
  a_grant_lag: assert property (p_grant_lag) else $error("grant without request");
  property p_mem_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata); endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request changed before ack");
  property p_mem_gap; mem_ack |=> !mem_req; endproperty
  a_mem_gap: assert property (p_mem_gap) else $error("no idle cycle after ack");
  property p_irq_pulse; |irq_req |=> irq_req == '0; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
  property p_irq_cause; |irq_req |-> $past(mem_ack) && $past(mem_we); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt not after write back");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  c_irq: cover property (|irq_req);
  c_grant: cover property (cpu_bus_grant);
  c_wait: cover property (mem_req && !mem_ack ##1 mem_req);
endmodule
bind itdm_data_mover itdm_data_mover_checker #(.NSRC(NSRC)) u_chk (.aclk, .aresetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cpu_bus_req, .cpu_bus_grant, .mem_req,
  .mem_we, .mem_addr, .mem_wdata, .mem_ack, .irq_req);

/* dv/itdm_mem_model.sv */
// Byte wide system memory that answers the data mover's bus requests.
`timescale 1ns/1ns
module itdm_mem_model (
  input  wire logic        aclk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata,
  output logic             mem_ack
);
  logic [7:0] mem [0:65535];  // Flat 64 Kbyte space holding control data too.
  int         wait_n = 0;     // Wait cycles spent on the current access.
  initial {mem_ack, mem_rdata} = {1'b0, 8'hA5};
  // Answers after zero or three waits; read data toggles on every cycle except a read acknowledge.
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (wait_n >= (slow ? 3 : 0)) begin
        mem_ack <= 1'b1;
        wait_n <= 0;
        if (mem_we) mem[mem_addr] <= mem_wdata;
        else mem_rdata <= mem[mem_addr];
      end else begin
        wait_n <= wait_n + 1;
      end
    end
  end
endmodule

/* dv/itdm_data_mover_tb_top.sv */
// Self-checking testbench for the data mover.
`timescale 1ns/1ns
module itdm_data_mover_tb_top;
  import itdm_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nmi_event;
  logic        cpu_bus_req, cpu_bus_grant, mem_req, mem_we, mem_ack, slow;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, mem_wdata, mem_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] mem_addr;
  logic [23:0] act_event, irq_req;
  logic [23:0] irq_seen = '0;  // Every interrupt pulse seen so far.
  int          n_mismatch = 0;
  int          checks_done = 0;
  itdm_data_mover dut (.*);
  itdm_mem_model u_mem (.aclk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) if (aresetn) irq_seen <= irq_seen | irq_req;
  // ****************************************************************
  // Tasks for register access, control data and comparison.
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (2) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Control byte first, addresses low byte first.
  task automatic set_cd(input int j, input logic [7:0] c, b, n, input logic [15:0] s, d);
    logic [63:0] v;
    v = {d, s, n, n, b, c};
    for (int k = 0; k < 8; k++) u_mem.mem[ITDM_CD_BASE + 16'(8 * j + k)] = v[8*k +: 8];
  endtask
  function automatic logic [31:0] cd(input int j, input int k);
    return 32'(u_mem.mem[ITDM_CD_BASE + 16'(8 * j + k)]);
  endfunction
  // Pulses the sources in m, then polls the status until the engine is idle.
  task automatic fire(input logic [23:0] m);
    @(posedge aclk);
    act_event <= m;
    @(posedge aclk);
    act_event <= '0;
    repeat (4) @(posedge aclk);
    for (int t = 0; t < 400; t++) begin
      axi_rd(ITDM_STATUS_OFS);
      if (rd[2:0] === 3'h0) break;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {nmi_event, cpu_bus_req, slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata, act_event} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    cpu_bus_req <= 1'b1;
    axi_rd(ITDM_ACT_EN_OFS);
    chk("enable reset", 32'h0, rd);
    axi_rd(8'h10);
    chk("unmapped resp", 32'(ITDM_RESP_SLVERR), 32'(rs));
    axi_wr(8'h10, 32'h0);
    chk("unmapped wr", 32'(ITDM_RESP_SLVERR), 32'(rs));
    // Normal mode, both sides increment, single final transfer.
    for (int k = 0; k < 3; k++) u_mem.mem[16'h1000 + 16'(k)] = 8'(8'h11 * (k + 1));
    set_cd(2, 8'h0C, 8'h03, 8'h01, 16'h1000, 16'h2000);
    axi_wr(ITDM_ACT_EN_OFS, 32'h4);
    fire(24'h4);
    for (int k = 0; k < 3; k++) chk("moved", 32'(8'h11 * (k + 1)), 32'(u_mem.mem[16'h2000 + 16'(k)]));
    chk("count", 32'h0, cd(2, ITDM_CD_CNT));
    chk("src lo", 32'h3, cd(2, ITDM_CD_SAR));
    chk("dst lo", 32'h3, cd(2, ITDM_CD_DAR));
    axi_rd(ITDM_ACT_EN_OFS);
    chk("enable cleared", 32'h0, rd);
    // Repeat mode on a slow memory, destination repeats, source fixed.
    slow <= 1'b1;
    set_cd(5, 8'h01, 8'h02, 8'h01, 16'h1000, 16'h3000);
    axi_wr(ITDM_ACT_EN_OFS, 32'h20);
    fire(24'h20);
    chk("fixed src", 32'h11, 32'(u_mem.mem[16'h3001]));
    chk("reload", 32'h1, cd(5, ITDM_CD_CNT));
    chk("restored", 32'h0, cd(5, ITDM_CD_DAR));
    axi_rd(ITDM_ACT_EN_OFS);
    chk("enable kept", 32'h20, rd);
    // The seen flag blocks activation until software clears it.
    u_mem.mem[16'h1000] = 8'h77;
    @(posedge aclk);
    nmi_event <= 1'b1;
    @(posedge aclk);
    nmi_event <= 1'b0;
    axi_rd(ITDM_ACT_CTL_OFS);
    chk("flag set", 32'h2, rd);
    fire(24'h20);
    chk("blocked", 32'h11, 32'(u_mem.mem[16'h3000]));
    axi_wr(ITDM_ACT_CTL_OFS, 32'h0);
    axi_rd(ITDM_ACT_CTL_OFS);
    chk("flag clear", 32'h0, rd);
    fire(24'h20);
    chk("resumed", 32'h77, 32'(u_mem.mem[16'h3000]));
    // Chain of two sets from one activation.
    slow <= 1'b0;
    set_cd(7, 8'h1C, 8'h01, 8'h02, 16'h1001, 16'h4000);
    set_cd(8, 8'h0C, 8'h01, 8'h01, 16'h1002, 16'h4001);
    axi_wr(ITDM_ACT_EN_OFS, 32'h80);
    fire(24'h80);
    chk("chain first", 32'h22, 32'(u_mem.mem[16'h4000]));
    chk("chain second", 32'h33, 32'(u_mem.mem[16'h4001]));
    chk("count first", 32'h1, cd(7, ITDM_CD_CNT));
    chk("count second", 32'h0, cd(8, ITDM_CD_CNT));
    axi_rd(ITDM_ACT_EN_OFS);
    chk("chain enable", 32'h80, rd);
    chk("irq seen", 32'h4, 32'(irq_seen));
    // Block and count of 00h, then two sources at once, lowest index first.
    set_cd(9, 8'h0C, 8'h00, 8'h00, 16'h1000, 16'h5000);
    set_cd(10, 8'h08, 8'h01, 8'h02, 16'h1000, 16'h6000);
    set_cd(11, 8'h08, 8'h01, 8'h02, 16'h1001, 16'h6000);
    axi_wr(ITDM_ACT_EN_OFS, 32'hE00);
    fire(24'h200);
    chk("big block", 32'h51, cd(9, ITDM_CD_DAR + 1));
    chk("count 256", 32'hFF, cd(9, ITDM_CD_CNT));
    fire(24'hC00);
    repeat (100) @(posedge aclk);
    chk("priority", 32'h22, 32'(u_mem.mem[16'h6000]));
    chk("grant idle", 32'h1, 32'(cpu_bus_grant));
    report_and_stop();
  end
endmodule
